/* File: hdl/flyback_pkg.sv */
// Constants and types shared by the flyback protection sequencer
package flyback_pkg;
  localparam int unsigned clk_hz = 40000000;
  localparam int unsigned blank_std_ms = 68;
  localparam int unsigned blank_alt_ms = 136;
  localparam int unsigned softstart_ms = 8;
  localparam int unsigned deglitch_ns = 600;
  localparam int unsigned blank_std_cycles = blank_std_ms * (clk_hz / 1000);
  localparam int unsigned blank_alt_cycles = blank_alt_ms * (clk_hz / 1000);
  localparam int unsigned softstart_cycles = softstart_ms * (clk_hz / 1000);
  localparam int unsigned deglitch_cycles = (deglitch_ns * (clk_hz / 1000000) + 999) / 1000;
  localparam int unsigned fault_cycles_to_latch = 4;
  localparam int unsigned timer_width = 23;
  localparam int unsigned comp_width = 8;
  localparam logic [comp_width-1:0] comp_reset = 8'h00;

  typedef enum logic [2:0] {
    st_off = 3'b000,
    st_charge = 3'b001,
    st_run = 3'b010,
    st_line_low = 3'b011,
    st_latched = 3'b100
  } seq_state_type;
endpackage

/* File: hdl/sync_deglitch.sv */
// Two-flop synchroniser with minimum-high-time validation
`timescale 1ns/1ps
module sync_deglitch #(
  parameter int unsigned min_cycles = 24
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic raw_in,
  output logic sync_out,
  output logic valid_out
);
  logic meta_q;
  logic sync_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic valid_q;
  wire cnt_done = (cnt_q >= 8'(min_cycles));
  assign cnt_d = !sync_q ? 8'h00 : (cnt_done ? cnt_q : cnt_q + 8'h01);
  assign sync_out = sync_q;
  assign valid_out = valid_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      cnt_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      cnt_q <= cnt_d;
      valid_q <= sync_q && (cnt_q + 8'h01 >= 8'(min_cycles));
    end
  end
endmodule

/* File: hdl/flyback_protection_sequencer.sv */
// Protection sequencer: line undervoltage, compensation gating, fault pin
`timescale 1ns/1ps
module flyback_protection_sequencer #(
  parameter int unsigned blank_std = flyback_pkg::blank_std_cycles,
  parameter int unsigned blank_alt = flyback_pkg::blank_alt_cycles,
  parameter int unsigned softstart = flyback_pkg::softstart_cycles
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic line_above_off,
  input wire logic line_above_on,
  input wire logic supply_low_level,
  input wire logic supply_start_level,
  input wire logic supply_clear_level,
  input wire logic high_trip_raw,
  input wire logic low_trip_raw,
  input wire logic drive_clock_tick,
  input wire logic alt_blanking,
  input wire logic fault_autorecover,
  input wire logic [flyback_pkg::comp_width-1:0] fb_above_fold,
  output logic gate_drive_enable,
  output logic startup_source_on,
  output logic thermal_bias_on,
  output logic thermal_bias_double,
  output logic soft_start_active,
  output logic fault_latched,
  output logic [flyback_pkg::comp_width-1:0] line_power_compensation
);
  import flyback_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [4:0] raw_vec;
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  assign raw_vec = {line_above_off, line_above_on, supply_low_level,
                    supply_start_level, supply_clear_level};
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      s1_q <= raw_vec;
      s2_q <= s1_q;
    end
  end
  wire line_ok = s2_q[4];
  wire line_on = s2_q[3];
  wire vcc_min = s2_q[2];
  wire vcc_on = s2_q[1];
  wire vcc_clear = s2_q[0];

  logic hi_sync;
  logic lo_sync;
  logic hi_valid;
  logic lo_valid;
  sync_deglitch #(.min_cycles(deglitch_cycles)) u_hi (
    .mclk(mclk), .resetn(resetn), .raw_in(high_trip_raw),
    .sync_out(hi_sync), .valid_out(hi_valid)
  );
  sync_deglitch #(.min_cycles(deglitch_cycles)) u_lo (
    .mclk(mclk), .resetn(resetn), .raw_in(low_trip_raw),
    .sync_out(lo_sync), .valid_out(lo_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  seq_state_type state_q;
  seq_state_type state_d;
  logic [timer_width-1:0] blank_q;
  logic [timer_width-1:0] ss_q;
  logic [2:0] fcnt_q;
  logic cyc_fault_q;
  logic line_was_low_q;

  wire [timer_width-1:0] blank_lim = alt_blanking ? timer_width'(blank_alt)
                                                  : timer_width'(blank_std);
  wire blank_done = (blank_q >= blank_lim);
  wire ss_on = (ss_q != '0);
  wire run = (state_q == st_run);
  wire lo_event = lo_valid && !ss_on;
  wire pin_event = hi_valid || lo_event;
  wire cyc_fault = cyc_fault_q || pin_event;
  wire trip_now = run && drive_clock_tick && cyc_fault &&
                  (fcnt_q == 3'(fault_cycles_to_latch - 1));
  wire line_recover = line_was_low_q && line_on;
  wire ss_start = (state_q != st_run) && (state_d == st_run);

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_off: if (vcc_on) state_d = line_on ? st_run : st_line_low;
      st_charge: if (vcc_on) state_d = line_on ? st_run : st_line_low;
      st_run: begin
        if (trip_now && !fault_autorecover) state_d = st_latched;
        else if (trip_now) state_d = st_charge;
        else if (!line_ok && blank_done) state_d = st_line_low;
        else if (!vcc_min) state_d = st_charge;
      end
      st_line_low: if (vcc_on && line_on) state_d = st_run;
      st_latched: if (!vcc_clear || line_recover) state_d = st_charge;
      default: state_d = st_off;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) state_q <= st_off;
    else state_q <= state_d;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blank_q <= '0;
    end else if (run && !line_ok) begin
      if (!blank_done) blank_q <= blank_q + 1'b1;
    end else begin
      blank_q <= '0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ss_q <= '0;
    else if (ss_start) ss_q <= timer_width'(softstart);
    else if (ss_on && run) ss_q <= ss_q - 1'b1;
    else if (!run) ss_q <= '0;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fcnt_q <= 3'h0;
      cyc_fault_q <= 1'b0;
    end else if (!run) begin
      fcnt_q <= 3'h0;
      cyc_fault_q <= 1'b0;
    end else if (drive_clock_tick) begin
      fcnt_q <= cyc_fault ? fcnt_q + 3'h1 : 3'h0;
      cyc_fault_q <= 1'b0;
    end else begin
      cyc_fault_q <= cyc_fault;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) line_was_low_q <= 1'b0;
    else if (!line_ok) line_was_low_q <= 1'b1;
    else if (line_on) line_was_low_q <= 1'b0;
  end

  wire [comp_width-1:0] comp_d = run ? fb_above_fold : comp_reset;

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gate_drive_enable <= 1'b0;
      startup_source_on <= 1'b0;
      thermal_bias_on <= 1'b0;
      thermal_bias_double <= 1'b0;
      soft_start_active <= 1'b0;
      fault_latched <= 1'b0;
      line_power_compensation <= comp_reset;
    end else begin
      gate_drive_enable <= (state_d == st_run);
      startup_source_on <= (state_d != st_run) && (!vcc_min ||
                           (startup_source_on && !vcc_on));
      thermal_bias_on <= vcc_min;
      thermal_bias_double <= vcc_min && ss_on;
      soft_start_active <= ss_on;
      fault_latched <= (state_d == st_latched);
      line_power_compensation <= comp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_latch_drive_off: assert property (@(posedge mclk) disable iff (!resetn)
    fault_latched |-> !gate_drive_enable) else $error("drive while latched");
  a_ss_low_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    (ss_on && !hi_valid) |-> !pin_event) else $error("low trip in soft-start");
  a_trip_latches: assert property (@(posedge mclk) disable iff (!resetn)
    (trip_now && !fault_autorecover) |=> fault_latched) else $error("no latch");
  a_clean_clears: assert property (@(posedge mclk) disable iff (!resetn)
    (run && drive_clock_tick && !cyc_fault) |=> fcnt_q == 3'h0) else $error("cnt kept");
  a_bias_gated: assert property (@(posedge mclk) disable iff (!resetn)
    thermal_bias_on |-> $past(vcc_min)) else $error("bias early");
  a_double_ss: assert property (@(posedge mclk) disable iff (!resetn)
    thermal_bias_double |-> $past(ss_on)) else $error("double outside ss");
  a_ss_start: assert property (@(posedge mclk) disable iff (!resetn)
    ss_start |=> ss_q == timer_width'(softstart)) else $error("ss not loaded");
  a_comp_gated: assert property (@(posedge mclk) disable iff (!resetn)
    !run |=> line_power_compensation == comp_reset) else $error("comp active");
  a_short_glitch: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(hi_valid) |-> $past(hi_sync, 24) && !$past(hi_sync, 25))
    else $error("glitch accepted");
  a_source_line_low: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == st_line_low && !vcc_min) |=> startup_source_on) else $error("no recharge");
  c_latch: cover property (@(posedge mclk) disable iff (!resetn) $rose(fault_latched));
  c_autorestart: cover property (@(posedge mclk) disable iff (!resetn)
    trip_now && fault_autorecover);
  c_line_low: cover property (@(posedge mclk) disable iff (!resetn)
    run ##1 state_q == st_line_low);
  c_recover: cover property (@(posedge mclk) disable iff (!resetn)
    fault_latched ##1 !fault_latched);
endmodule

/* File: dv/flyback_stage_model.sv */
// Behavioural power stage: supply capacitor hiccup and drive cycle ticks
`timescale 1ns/1ps
module flyback_stage_model (
  input wire logic mclk,
  input wire logic startup_source_on,
  input wire logic gate_drive_enable,
  input wire logic unplug,
  output logic supply_low_level,
  output logic supply_start_level,
  output logic supply_clear_level,
  output logic drive_clock_tick
);
  int vcc = 0;
  int div = 0;
  int phase = 0;
  always @(posedge mclk) begin
    div <= div + 1;
    phase <= gate_drive_enable ? (phase + 1) % 10 : 0;
    if (unplug) begin
      vcc <= 0;
    end else if (startup_source_on) begin
      vcc <= (vcc < 130) ? vcc + 1 : vcc;
    end else if (!gate_drive_enable && div % 4 == 0 && vcc > 0) begin
      vcc <= vcc - 1;
    end
  end
  assign supply_low_level = vcc >= 100;
  assign supply_start_level = vcc >= 120;
  assign supply_clear_level = vcc > 20;
  assign drive_clock_tick = gate_drive_enable && phase == 9;
endmodule

/* File: dv/flyback_protection_sequencer_bench.sv */
// Self-checking bench for the flyback protection sequencer
`timescale 1ns/1ps
module flyback_protection_sequencer_bench;
  import flyback_pkg::*;
  localparam int unsigned blank_s = 50;
  localparam int unsigned blank_a = 100;
  logic mclk = 0, resetn = 0, off_ok = 1, on_ok = 1, hi = 0, lo = 0;
  logic alt = 0, auto_rec = 0, unplug = 0, probe = 0;
  logic [comp_width-1:0] fb = 8'h00;
  logic low_lvl, start_lvl, clr_lvl, tick, gate, src, bias, dbl, ss, latched;
  logic [comp_width-1:0] comp;
  logic [13:0] obs;
  logic [27:0] notes[$];
  logic [31:0] seed = 32'heba9;
  int mismatches = 0, comparisons = 0;
  assign obs = {gate, latched, ss, dbl, bias, src, comp};
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  flyback_protection_sequencer #(.blank_std(blank_s), .blank_alt(blank_a), .softstart(80)) uut (
    .mclk(mclk), .resetn(resetn), .line_above_off(off_ok), .line_above_on(on_ok),
    .supply_low_level(low_lvl), .supply_start_level(start_lvl),
    .supply_clear_level(clr_lvl), .high_trip_raw(hi), .low_trip_raw(lo),
    .drive_clock_tick(tick), .alt_blanking(alt), .fault_autorecover(auto_rec),
    .fb_above_fold(fb), .gate_drive_enable(gate), .startup_source_on(src),
    .thermal_bias_on(bias), .thermal_bias_double(dbl), .soft_start_active(ss),
    .fault_latched(latched), .line_power_compensation(comp));
  flyback_stage_model stage (.mclk(mclk), .startup_source_on(src),
    .gate_drive_enable(gate), .unplug(unplug), .supply_low_level(low_lvl),
    .supply_start_level(start_lvl), .supply_clear_level(clr_lvl), .drive_clock_tick(tick));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic note(input logic [13:0] mask, input logic [13:0] exp);
    notes.push_back({mask, exp});
    probe = 1;
    step(1);
    probe = 0;
  endtask
  task automatic wait_bit(input int b, input logic val);
    for (int i = 0; i < 800 && obs[b] !== val; i++) step(1);
    if (obs[b] !== val) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, obs[b], val);
    end
  endtask
  task automatic trip(input logic upper, input int n);
    hi = upper;
    lo = !upper;
    step(n);
    hi = 0;
    lo = 0;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge probe) begin
    logic [27:0] n;
    n = notes.pop_front();
    comparisons++;
    if (((obs ^ n[13:0]) & n[27:14]) !== 14'h0) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, obs, n[13:0]);
    end
  end
  initial begin
    #750000;
    mismatches++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(16);
    resetn = 1;
    wait_bit(13, 1);
    step(2);
    note(14'h3e00, 14'h2e00);
    trip(0, 70);
    step(40);
    note(14'h3c00, 14'h2000);
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      fb = seed[7:0];
      step(3);
      note(14'h00ff, {6'h0, fb});
    end
    for (int g = 0; g < 6; g++) begin
      seed = xorshift(seed);
      trip(1, 8 + int'(seed[3:0]));
      step(2);
    end
    step(60);
    note(14'h3c00, 14'h2000);
    trip(1, 80);
    note(14'h30ff, 14'h1000);
    wait_bit(8, 1);
    note(14'h3100, 14'h1100);
    unplug = 1;
    step(4);
    unplug = 0;
    step(4);
    note(14'h1000, 14'h0000);
    wait_bit(13, 1);
    step(60);
    trip(0, 80);
    note(14'h3000, 14'h1000);
    off_ok = 0;
    on_ok = 0;
    step(30);
    off_ok = 1;
    on_ok = 1;
    wait_bit(13, 1);
    note(14'h3000, 14'h2000);
    for (int a = 0; a < 2; a++) begin
      alt = a[0];
      step(60);
      off_ok = 0;
      on_ok = 0;
      step((a == 1 ? blank_a : blank_s) - 10);
      note(14'h2000, 14'h2000);
      step(20);
      note(14'h2000, 14'h0000);
      wait_bit(8, 1);
      note(14'h2100, 14'h0100);
      wait_bit(8, 0);
      step(20);
      note(14'h2000, 14'h0000);
      off_ok = 1;
      on_ok = 1;
      wait_bit(13, 1);
    end
    step(60);
    auto_rec = 1;
    trip(1, 80);
    note(14'h1000, 14'h0000);
    wait_bit(11, 1);
    note(14'h3800, 14'h2800);
    conclude();
  end
endmodule
